// *** hdl/rtc_pkg.sv ***
// What this block does
// (R1) freq bit, chip deselected: pulse pin at 256 Hz
// (R2) host leaves data line undriven while measuring
// (R3) accel bit alone: timekeeping runs 32x faster
// (R4) parallel bit alone: fields step independently 1 Hz
// (R5) both bits: independent steps 32 Hz; none: normal
// (R6) software clears both test bits to leave test
// (R7) software reloads time and date after test
// (R8) external generator drives divider, rate scales
// (R9) host never starts access mid cycle
// (R10) partial serial cycle held forever, no timeout
// (R11) out-of-range field clears on next increment
// (R12) four address bits then eight data, lsb first
// (R13) chip selected: measurement current disabled
`default_nettype none
package rtc_pkg;
  // host strobe timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int PHASE_NS = 200;
  localparam int PHASE_CYCLES = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PHASE_W = 4;
  // device ram map and commands
  localparam logic [3:0] ADDR_STATUS0 = 4'h0;
  localparam logic [3:0] ADDR_STATUS1 = 4'h1;
  localparam logic [3:0] ADDR_LAST_FIELD = 4'h9;
  localparam int FIRST_FIELD_ADDR = 2;
  localparam int RAM_WORDS = 10;
  localparam logic [3:0] CMD_RAM_TO_CLOCK = 4'he;
  localparam logic [3:0] CMD_CLOCK_TO_RAM = 4'hf;
  localparam int ADDR_BITS = 4;
  localparam int DATA_BITS = 8;
  localparam logic [3:0] LAST_ADDR_BIT = 4'd3;
  localparam logic [3:0] FIRST_DATA_BIT = 4'd4;
  localparam logic [3:0] LAST_DATA_BIT = 4'd11;
  // control_status_zero fields
  localparam int ST0_FREQ_BIT = 0;
  localparam int ST0_ACCEL_BIT = 2;
  localparam int ST0_PAR_BIT = 3;
  localparam int ST0_LOCK_BIT = 4;
  localparam logic [7:0] ST0_RESET = 8'h00;
  // divider chain from the oscillator pin
  localparam int OSC_DIV_W = 15;
  localparam int OSC_FAST_W = 10;
  localparam int FREQ_HALF_W = 6;
  // time and date fields
  localparam int FIELDS = 8;
  localparam int F_SEC = 0;
  localparam int F_MIN = 1;
  localparam int F_HOUR = 2;
  localparam int F_DOM = 3;
  localparam int F_MONTH = 4;
  localparam int F_YEAR = 5;
  localparam int F_WDAY = 6;
  localparam int F_WEEK = 7;
  localparam logic [7:0] FIELD_MIN [FIELDS] = '{8'h00, 8'h00, 8'h00, 8'h01,
                                               8'h01, 8'h00, 8'h01, 8'h00};
  localparam logic [7:0] FIELD_MAX [FIELDS] = '{8'h59, 8'h59, 8'h23, 8'h31,
                                               8'h12, 8'h99, 8'h07, 8'h52};
  localparam logic [7:0] FEB = 8'h02;
  localparam logic [7:0] APR = 8'h04;
  localparam logic [7:0] JUN = 8'h06;
  localparam logic [7:0] SEP = 8'h09;
  localparam logic [7:0] NOV = 8'h11;
  localparam logic [7:0] DOM_28 = 8'h28;
  localparam logic [7:0] DOM_29 = 8'h29;
  localparam logic [7:0] DOM_30 = 8'h30;
  // host register map, axi4-lite
  localparam int AXI_AW = 4;
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int CMD_ADDR_LSB = 0;
  localparam int CMD_WDATA_LSB = 8;
  localparam int CMD_OP_LSB = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RDATA_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    OP_ADDR_CMD = 2'd0,
    OP_WRITE = 2'd1,
    OP_READ = 2'd2,
    OP_INIT = 2'd3
  } op_t;
  localparam logic [3:0] NBITS_ADDR = 4'd4;
  localparam logic [3:0] NBITS_DATA = 4'd12;
  localparam logic [3:0] NBITS_INIT = 4'd8;
  typedef enum logic [4:0] {
    H_IDLE = 5'b00001,
    H_SETUP = 5'b00010,
    H_STROBE = 5'b00100,
    H_HOLD = 5'b01000,
    H_GAP = 5'b10000
  } host_state_t;
endpackage
`default_nettype wire

// *** hdl/rtc_link_if.sv ***
`default_nettype none
interface rtc_link_if;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic host_io_out;
  logic host_io_oe;
  logic dev_io_out;
  logic dev_io_oe;
  logic io_level;
  // shared line, pulled low when nobody drives
  assign io_level = host_io_oe ? host_io_out : (dev_io_oe ? dev_io_out : 1'b0);
  modport device(input cs_n, input rd_n, input wr_n, input io_level,
                 output dev_io_out, output dev_io_oe);
  modport host(output cs_n, output rd_n, output wr_n, output host_io_out,
               output host_io_oe, input io_level);
endinterface
`default_nettype wire

// *** hdl/bcd_field.sv ***
`default_nettype none
module bcd_field (
  // current value and limits
  input wire logic [7:0] cur,
  input wire logic [7:0] min_val,
  input wire logic [7:0] max_val,
  // incremented value
  output logic [7:0] nxt,
  output logic wrap
);
  logic valid;
  always_comb begin
    valid = (cur[3:0] <= 4'h9) && (cur[7:4] <= 4'h9) && (cur >= min_val) && (cur <= max_val);
    nxt = cur;
    wrap = 1'b0;
    if (!valid) begin
      nxt = 8'h00; // [R11]
    end else if (cur == max_val) begin
      nxt = min_val;
      wrap = 1'b1;
    end else if (cur[3:0] == 4'h9) begin
      nxt = {cur[7:4] + 4'h1, 4'h0};
    end else begin
      nxt = cur + 8'h01;
    end
  end
endmodule
`default_nettype wire

// *** hdl/rtc_device.sv ***
`default_nettype none
module rtc_device import rtc_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // serial link
  rtc_link_if.device link,
  // crystal or external generator
  input wire logic oscillator_output_pin
);
  // pin synchronisers: cs, rd, wr, io, osc
  logic [4:0] meta_q;
  logic [4:0] sync_q;
  logic [4:0] last_q;
  logic [OSC_DIV_W-1:0] pre_q;
  logic fm_q;
  logic [3:0] cnt_q;
  logic [3:0] addr_q;
  logic [7:0] sh_q;
  logic [7:0] ram_q [RAM_WORDS];
  logic [7:0] clk_q [FIELDS];
  logic [FIELDS-1:0] chg_q;
  logic io_out_q;
  logic io_oe_q;
  logic cs_act;
  logic io_bit;
  logic wr_stb;
  logic rd_fall;
  logic rd_rise;
  logic osc_rise;
  logic tick;
  logic accel;
  logic par;
  logic [3:0] full_addr;
  logic addr_done;
  logic do_e;
  logic do_f;
  logic ram_wr;
  logic [7:0] wr_val;
  logic [2:0] rbit;
  logic leap;
  logic [7:0] dom_max;
  logic [7:0] fmax [FIELDS];
  logic [7:0] nxt [FIELDS];
  logic [FIELDS-1:0] wrap;
  logic [FIELDS-1:0] inc;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= 5'h0f;
      sync_q <= 5'h0f;
      last_q <= 5'h0f;
    end else begin
      meta_q <= {oscillator_output_pin, link.io_level, link.wr_n, link.rd_n, link.cs_n};
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign cs_act = !sync_q[0];
  assign io_bit = sync_q[3];
  assign wr_stb = cs_act && sync_q[2] && !last_q[2];
  assign rd_fall = cs_act && !sync_q[1] && last_q[1];
  assign rd_rise = cs_act && sync_q[1] && !last_q[1];
  assign osc_rise = sync_q[4] && !last_q[4]; // [R8]
  assign accel = ram_q[ADDR_STATUS0][ST0_ACCEL_BIT];
  assign par = ram_q[ADDR_STATUS0][ST0_PAR_BIT];

  // divider chain; rate follows the oscillator pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q <= '0;
    end else if (osc_rise) begin
      pre_q <= pre_q + 1'b1; // [R8]
    end
  end

  // 32x when the accel bit is set, in either mode
  assign tick = osc_rise && (accel ? (&pre_q[OSC_FAST_W-1:0]) : (&pre_q)); // [R3] [R5]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fm_q <= 1'b0;
    end else if (osc_rise && (&pre_q[FREQ_HALF_W-1:0])) begin
      fm_q <= !fm_q; // [R1]
    end
  end

  // month length with leap years
  always_comb begin
    if (clk_q[F_YEAR][4]) begin
      leap = (clk_q[F_YEAR][3:0] == 4'h2) || (clk_q[F_YEAR][3:0] == 4'h6);
    end else begin
      leap = (clk_q[F_YEAR][3:0] == 4'h0) || (clk_q[F_YEAR][3:0] == 4'h4) ||
             (clk_q[F_YEAR][3:0] == 4'h8);
    end
    case (clk_q[F_MONTH])
      FEB: dom_max = leap ? DOM_29 : DOM_28;
      APR, JUN, SEP, NOV: dom_max = DOM_30;
      default: dom_max = FIELD_MAX[F_DOM];
    endcase
    for (int i = 0; i < FIELDS; i++) begin
      fmax[i] = FIELD_MAX[i];
    end
    fmax[F_DOM] = dom_max;
  end

  genvar g;
  generate
    for (g = 0; g < FIELDS; g++) begin : g_field
      bcd_field u_field (
        .cur(clk_q[g]),
        .min_val(FIELD_MIN[g]),
        .max_val(fmax[g]),
        .nxt(nxt[g]),
        .wrap(wrap[g])
      );
    end
  endgenerate

  // carry chain, or every field at once in parallel mode
  always_comb begin
    if (par) begin
      inc = {FIELDS{tick}}; // [R4] [R5]
    end else begin
      inc[F_SEC] = tick; // [R5]
      inc[F_MIN] = inc[F_SEC] && wrap[F_SEC];
      inc[F_HOUR] = inc[F_MIN] && wrap[F_MIN];
      inc[F_DOM] = inc[F_HOUR] && wrap[F_HOUR];
      inc[F_WDAY] = inc[F_HOUR] && wrap[F_HOUR];
      inc[F_MONTH] = inc[F_DOM] && wrap[F_DOM];
      inc[F_YEAR] = inc[F_MONTH] && wrap[F_MONTH];
      inc[F_WEEK] = inc[F_WDAY] && wrap[F_WDAY];
    end
  end

  // serial decode
  assign full_addr = {io_bit, addr_q[2:0]};
  assign addr_done = wr_stb && (cnt_q == LAST_ADDR_BIT);
  assign do_e = addr_done && (full_addr == CMD_RAM_TO_CLOCK) &&
                !ram_q[ADDR_STATUS0][ST0_LOCK_BIT];
  assign do_f = addr_done && (full_addr == CMD_CLOCK_TO_RAM);
  assign ram_wr = wr_stb && (cnt_q == LAST_DATA_BIT) && (addr_q <= ADDR_LAST_FIELD);
  assign wr_val = {io_bit, sh_q[7:1]};
  assign rbit = 3'(cnt_q - FIRST_DATA_BIT);

  // no timeout: state waits for the next strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      addr_q <= '0;
      sh_q <= '0;
    end else if (wr_stb) begin
      if (cnt_q < FIRST_DATA_BIT) begin
        addr_q[cnt_q[1:0]] <= io_bit; // [R12]
        if (addr_done && (full_addr == CMD_RAM_TO_CLOCK || full_addr == CMD_CLOCK_TO_RAM)) begin
          cnt_q <= '0;
        end else begin
          cnt_q <= cnt_q + 4'd1; // [R10]
        end
      end else begin
        sh_q <= wr_val; // [R12]
        cnt_q <= (cnt_q == LAST_DATA_BIT) ? 4'd0 : cnt_q + 4'd1;
      end
    end else if (rd_rise) begin
      if (cnt_q < FIRST_DATA_BIT) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= (cnt_q == LAST_DATA_BIT) ? 4'd0 : cnt_q + 4'd1; // [R10]
      end
    end
  end

  // ram: serial writes and copies from the clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < RAM_WORDS; i++) begin
        ram_q[i] <= 8'h00;
      end
      ram_q[ADDR_STATUS0] <= ST0_RESET;
    end else begin
      if (ram_wr) begin
        ram_q[addr_q] <= wr_val;
      end
      if (do_f) begin
        for (int i = 0; i < FIELDS; i++) begin
          ram_q[i + FIRST_FIELD_ADDR] <= clk_q[i];
        end
        ram_q[ADDR_STATUS1] <= chg_q;
      end
      if (do_e) begin
        ram_q[ADDR_STATUS1] <= 8'h00;
      end
    end
  end

  // running clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < FIELDS; i++) begin
        clk_q[i] <= FIELD_MIN[i];
      end
    end else if (do_e) begin
      for (int i = 0; i < FIELDS; i++) begin
        clk_q[i] <= ram_q[i + FIRST_FIELD_ADDR];
      end
    end else begin
      for (int i = 0; i < FIELDS; i++) begin
        if (inc[i]) begin
          clk_q[i] <= nxt[i]; // [R4] [R11]
        end
      end
    end
  end

  // change flags; a new step wins over the clock-to-ram copy's clear, the ram-to-clock copy clears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chg_q <= '0;
    end else if (do_f || do_e) begin
      chg_q <= do_e ? '0 : inc;
    end else begin
      chg_q <= chg_q | inc;
    end
  end

  // pin drive: read data when selected, measurement pulse when not
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      io_out_q <= 1'b0;
      io_oe_q <= 1'b0;
    end else if (cs_act) begin
      io_out_q <= (addr_q <= ADDR_LAST_FIELD) ? ram_q[addr_q][rbit] : 1'b0; // [R12]
      io_oe_q <= !sync_q[1] && (cnt_q >= FIRST_DATA_BIT) && !rd_fall; // [R13]
    end else begin
      io_out_q <= 1'b1;
      io_oe_q <= ram_q[ADDR_STATUS0][ST0_FREQ_BIT] && fm_q; // [R1]
    end
  end

  assign link.dev_io_out = io_out_q;
  assign link.dev_io_oe = io_oe_q;
endmodule
`default_nettype wire

// *** hdl/rtc_host.sv ***
`default_nettype none
module rtc_host import rtc_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // serial link
  rtc_link_if.host link
);
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic aw_got_q, w_got_q;
  logic [AXI_AW-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic io_meta_q, io_sync_q;
  host_state_t state_q;
  op_t op_q;
  logic busy_q;
  logic [3:0] haddr_q, bit_q, nbits_q;
  logic [7:0] hwdata_q, rbyte_q;
  logic [PHASE_W-1:0] div_q;
  logic cs_n_q, rd_n_q, wr_n_q, io_out_q, io_oe_q;
  logic both;
  logic start;
  logic en;
  logic cur_read;
  logic [3:0] next_bit;
  logic nxt_read;
  logic nxt_val;

  assign both = aw_got_q && w_got_q && !bvalid_q;
  assign start = both && (awaddr_q == REG_CMD) && !busy_q; // [R9]

  // write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (awvalid && awready_q) begin
        aw_got_q <= 1'b1;
        awready_q <= 1'b0;
        awaddr_q <= awaddr;
      end
      if (wvalid && wready_q) begin
        w_got_q <= 1'b1;
        wready_q <= 1'b0;
        wdata_q <= wdata;
      end
      if (both) begin
        bvalid_q <= 1'b1;
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        if (awaddr_q == REG_CMD) begin
          bresp_q <= busy_q ? RESP_SLVERR : RESP_OKAY; // [R9]
        end else begin
          bresp_q <= (awaddr_q == REG_STATUS) ? RESP_OKAY : RESP_SLVERR;
        end
      end
      if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
      if (araddr == REG_STATUS) begin
        rdata_q[STAT_BUSY_BIT] <= busy_q;
        rdata_q[STAT_RDATA_LSB +: 8] <= rbyte_q;
      end else if (araddr == REG_CMD) begin
        rdata_q[CMD_ADDR_LSB +: 4] <= haddr_q;
        rdata_q[CMD_WDATA_LSB +: 8] <= hwdata_q;
        rdata_q[CMD_OP_LSB +: 2] <= op_q;
      end else begin
        rresp_q <= RESP_SLVERR;
      end
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      io_meta_q <= 1'b0;
      io_sync_q <= 1'b0;
    end else begin
      io_meta_q <= link.io_level;
      io_sync_q <= io_meta_q;
    end
  end

  // phase divider, counts down to zero and reloads on start and on each enable, holding at zero only when idle; enable pulses only during a cycle
  assign en = (div_q == '0) && (state_q != H_IDLE);
  always_ff @(posedge aclk) begin
    if (!aresetn || start || en) begin
      div_q <= PHASE_W'(PHASE_CYCLES - 1);
    end else if (div_q != '0) begin
      div_q <= div_q - 1'b1;
    end
  end

  // bit kind and value, address lsb first then data lsb first
  assign cur_read = (op_q == OP_INIT) || ((op_q == OP_READ) && (bit_q >= FIRST_DATA_BIT));
  assign next_bit = bit_q + 4'd1;
  assign nxt_read = (op_q == OP_INIT) || ((op_q == OP_READ) && (next_bit >= FIRST_DATA_BIT));
  assign nxt_val = (next_bit < FIRST_DATA_BIT) ? haddr_q[next_bit[1:0]] :
                   hwdata_q[3'(next_bit - 4'd4)];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= H_IDLE;
      op_q <= OP_ADDR_CMD;
      busy_q <= 1'b0;
      haddr_q <= '0;
      hwdata_q <= '0;
      bit_q <= '0;
      nbits_q <= NBITS_ADDR;
      rbyte_q <= '0;
      cs_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      io_out_q <= 1'b0;
      io_oe_q <= 1'b0;
    end else begin
      case (state_q)
        H_IDLE: begin
          if (start) begin
            op_q <= op_t'(wdata_q[CMD_OP_LSB +: 2]);
            haddr_q <= wdata_q[CMD_ADDR_LSB +: 4];
            hwdata_q <= wdata_q[CMD_WDATA_LSB +: 8];
            case (op_t'(wdata_q[CMD_OP_LSB +: 2]))
              OP_ADDR_CMD: nbits_q <= NBITS_ADDR;
              OP_INIT: nbits_q <= NBITS_INIT;
              default: nbits_q <= NBITS_DATA;
            endcase
            busy_q <= 1'b1;
            bit_q <= '0;
            cs_n_q <= 1'b0;
            io_oe_q <= (wdata_q[CMD_OP_LSB +: 2] != OP_INIT); // [R12]
            io_out_q <= wdata_q[CMD_ADDR_LSB];
            state_q <= H_SETUP;
          end
        end
        H_SETUP: begin
          if (en) begin
            rd_n_q <= !cur_read;
            wr_n_q <= cur_read;
            state_q <= H_STROBE;
          end
        end
        H_STROBE: begin
          if (en) begin
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            if (cur_read && op_q == OP_READ) begin
              rbyte_q[3'(bit_q - 4'd4)] <= io_sync_q;
            end
            state_q <= H_HOLD;
          end
        end
        H_HOLD: begin
          if (en) begin
            cs_n_q <= 1'b1;
            io_oe_q <= 1'b0; // [R2]
            state_q <= H_GAP;
          end
        end
        H_GAP: begin
          if (en) begin
            if (next_bit == nbits_q) begin
              busy_q <= 1'b0;
              state_q <= H_IDLE;
            end else begin
              bit_q <= next_bit;
              cs_n_q <= 1'b0;
              io_oe_q <= !nxt_read;
              io_out_q <= nxt_val;
              state_q <= H_SETUP;
            end
          end
        end
        default: state_q <= H_IDLE;
      endcase
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign link.cs_n = cs_n_q;
  assign link.rd_n = rd_n_q;
  assign link.wr_n = wr_n_q;
  assign link.host_io_out = io_out_q;
  assign link.host_io_oe = io_oe_q;
endmodule
`default_nettype wire

// *** dv/rtc_link_monitor.sv ***
`default_nettype none
module rtc_link_monitor (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // link signals
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic host_io_out,
  input wire logic host_io_oe,
  input wire logic dev_io_out,
  input wire logic dev_io_oe,
  input wire logic io_level
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic strobe_n;
  assign strobe_n = wr_n & rd_n;
  sequence setup_ph;
    (!cs_n && strobe_n)[*8];
  endsequence
  sequence strobe_ph;
    (!cs_n && !strobe_n)[*8];
  endsequence
  sequence gap_ph;
    (cs_n && strobe_n && !host_io_oe)[*8];
  endsequence
  a_meas_pulse_high: assert property (dev_io_oe && cs_n |-> dev_io_out && io_level)
    else $error("measurement pulse not high on line");
  a_meas_off_sel: assert property ((!cs_n && rd_n)[*6] |-> !dev_io_oe)
    else $error("measurement current while selected");
  a_strobe_in_frame: assert property (!strobe_n |-> !cs_n)
    else $error("strobe outside chip select");
  a_setup_then_strobe: assert property ($fell(cs_n) |-> setup_ph ##1 !strobe_n)
    else $error("setup phase length wrong");
  a_strobe_width: assert property ($fell(strobe_n) |-> strobe_ph ##1 strobe_n)
    else $error("strobe width wrong");
  a_hold_then_gap: assert property ($rose(strobe_n) |-> setup_ph ##1 cs_n)
    else $error("hold phase length wrong");
  a_gap_released: assert property ($rose(cs_n) |-> gap_ph)
    else $error("line driven during gap");
  a_write_bit_driven: assert property (!wr_n |-> host_io_oe && io_level == host_io_out)
    else $error("write bit not driven by host");
  a_read_line_free: assert property (!rd_n |-> !host_io_oe)
    else $error("host drives line during read");
endmodule
`default_nettype wire

// *** dv/rtc_test_and_freq_measure_test.sv ***
`default_nettype none
module rtc_test_and_freq_measure_test import rtc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RISES_S = 32768;
  localparam int FAST = RISES_S / 32;
  localparam int MEAS_CLKS = 4 * RISES_S / 256;
  logic aclk, aresetn, osc;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  int num_errors, compares;
  rtc_link_if i_rtc_link_if ();
  rtc_host i_rtc_host (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .link(i_rtc_link_if.host));
  rtc_device i_rtc_device (.aclk(aclk), .aresetn(aresetn), .link(i_rtc_link_if.device),
    .oscillator_output_pin(osc));
  rtc_link_monitor i_rtc_link_monitor (.aclk(aclk), .aresetn(aresetn),
    .cs_n(i_rtc_link_if.cs_n), .rd_n(i_rtc_link_if.rd_n), .wr_n(i_rtc_link_if.wr_n),
    .host_io_out(i_rtc_link_if.host_io_out), .host_io_oe(i_rtc_link_if.host_io_oe),
    .dev_io_out(i_rtc_link_if.dev_io_out), .dev_io_oe(i_rtc_link_if.dev_io_oe),
    .io_level(i_rtc_link_if.io_level));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic wait_idle(output logic [31:0] s);
    logic [1:0] r;
    do begin
      axi_read(REG_STATUS, s, r);
    end while (s[STAT_BUSY_BIT] !== 1'b0);
  endtask
  task automatic link_op(input op_t op, input logic [3:0] a, input logic [7:0] d);
    logic [1:0] r;
    logic [31:0] s;
    axi_write(REG_CMD, {14'h0, op, d, 4'h0, a}, r);
    check({30'h0, r}, {30'h0, RESP_OKAY});
    wait_idle(s);
  endtask
  task automatic read_ram(input logic [3:0] a, input logic [7:0] exp);
    logic [1:0] r;
    logic [31:0] s;
    link_op(OP_READ, a, 8'h00);
    axi_read(REG_STATUS, s, r);
    check({24'h0, s[STAT_RDATA_LSB +: 8]}, {24'h0, exp});
  endtask
  task automatic osc_rises(input int n);
    repeat (n) begin
      @(posedge aclk);
      osc <= 1'b1;
      repeat (2) @(posedge aclk);
      osc <= 1'b0;
      @(posedge aclk);
    end
  endtask
  task automatic test_bus();
    logic [1:0] r;
    logic [31:0] s;
    axi_read(4'hc, s, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    check(s, 32'h0);
    axi_write(4'h8, 32'h0, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    axi_write(REG_CMD, {14'h0, OP_READ, 8'h00, 4'h0, ADDR_STATUS0}, r);
    check({30'h0, r}, {30'h0, RESP_OKAY});
    axi_write(REG_CMD, {14'h0, OP_WRITE, 8'hff, 4'h0, ADDR_STATUS0}, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    wait_idle(s);
    check({24'h0, s[STAT_RDATA_LSB +: 8]}, {24'h0, ST0_RESET});
    read_ram(ADDR_STATUS0, ST0_RESET);
  endtask
  task automatic test_parallel();
    link_op(OP_ADDR_CMD, CMD_CLOCK_TO_RAM, 8'h00);
    link_op(OP_WRITE, 4'h2, 8'h65);
    link_op(OP_ADDR_CMD, CMD_RAM_TO_CLOCK, 8'h00);
    link_op(OP_WRITE, ADDR_STATUS0, 8'h0c);
    osc_rises(3 * FAST + FAST / 2);
    link_op(OP_WRITE, ADDR_STATUS0, 8'h00);
    link_op(OP_ADDR_CMD, CMD_CLOCK_TO_RAM, 8'h00);
    for (int i = 0; i < FIELDS; i++) begin
      read_ram(4'(FIRST_FIELD_ADDR + i), i == F_SEC ? 8'h02 : FIELD_MIN[i] + 8'h03);
    end
  endtask
  task automatic test_accel();
    link_op(OP_WRITE, 4'h2, 8'h58);
    link_op(OP_WRITE, 4'h3, 8'h59);
    link_op(OP_ADDR_CMD, CMD_RAM_TO_CLOCK, 8'h00);
    link_op(OP_WRITE, ADDR_STATUS0, 8'h04);
    osc_rises(2 * FAST);
    link_op(OP_WRITE, ADDR_STATUS0, 8'h00);
    link_op(OP_ADDR_CMD, CMD_CLOCK_TO_RAM, 8'h00);
    read_ram(4'h2, 8'h00);
    read_ram(4'h3, 8'h00);
    read_ram(4'h4, 8'h04);
  endtask
  task automatic test_freq();
    int n;
    link_op(OP_WRITE, ADDR_STATUS0, 8'h01);
    read_ram(ADDR_STATUS0, 8'h01);
    fork
      osc_rises(400);
      begin
        n = 0;
        while (i_rtc_link_if.dev_io_oe !== 1'b0) @(posedge aclk);
        while (i_rtc_link_if.dev_io_oe !== 1'b1) @(posedge aclk);
        check({31'h0, i_rtc_link_if.io_level}, 32'h1);
        while (i_rtc_link_if.dev_io_oe !== 1'b0) begin
          @(posedge aclk);
          n++;
        end
        while (i_rtc_link_if.dev_io_oe !== 1'b1) begin
          @(posedge aclk);
          n++;
        end
        check(n, MEAS_CLKS);
      end
    join
    fork
      osc_rises(200);
      link_op(OP_WRITE, ADDR_STATUS0, 8'h00);
    join
    check({31'h0, i_rtc_link_if.dev_io_oe}, 32'h0);
  endtask
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  initial begin
    repeat (100000) @(posedge aclk);
    num_errors++;
    summarize();
  end
  initial begin
    aresetn = 1'b0;
    osc = 1'b0;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    link_op(OP_INIT, 4'h0, 8'h00);
    test_bus();
    test_parallel();
    test_accel();
    test_freq();
    summarize();
  end
endmodule
`default_nettype wire
